// ---- rtl/wdnmi_pkg.sv ----
// Purpose: Shared constants and types for the watchdog NMI timer.
// Assumes: 40 MHz core clock, 32.768 kHz low-speed crystal clock.
// Notes:   Register offsets are word indices; byte address is index * 4.
package wdnmi_pkg;

   // Tick derivation from the low-speed crystal
   localparam int unsigned LSC_FREQ_HZ  = 32768;
   localparam int unsigned TICK_FREQ_HZ = 256;
   localparam int unsigned LSC_DIV      = LSC_FREQ_HZ / TICK_FREQ_HZ;
   localparam int unsigned DIV_W        = 7;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LSC_DIV - 1);
   localparam logic [DIV_W-1:0] DIV_RST  = 7'h00;
   localparam logic [DIV_W-1:0] DIV_ONE  = 7'h01;

   // Watchdog counter
   localparam int unsigned CNT_W = 10;
   localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
   localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

   // Register indices and bus geometry
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned DATA_W = 32;
   localparam logic [15:0] CTRL_IDX    = 16'hFF07;
   localparam logic [15:0] STAT_IDX    = 16'hFF0C;
   localparam logic [15:0] IRQ_CLR_IDX = 16'hFF0D;
   localparam logic [15:0] IRQ_EN_IDX  = 16'hFF0E;
   localparam logic [15:0] COUNT_IDX   = 16'hFF0F;

   // Control register fields
   localparam int unsigned CTRL_CLR_BIT = 0;
   localparam int unsigned CTRL_EN_BIT  = 1;
   localparam logic        CTRL_EN_RST  = 1'b1;

   // Interrupt status, clear and enable layout
   localparam int unsigned IRQ_W            = 2;
   localparam int unsigned IRQ_TIMEOUT_BIT  = 0;
   localparam int unsigned IRQ_ACCEPT_BIT   = 1;
   localparam logic [IRQ_W-1:0] IRQ_RST     = 2'h0;

   // Vector presented with the non-maskable interrupt
   localparam logic [15:0] NMI_VECTOR = 16'h0100;

   // Bus slave states
   typedef enum logic [1:0] {
      WDNMI_BUS_IDLE = 2'b01,
      WDNMI_BUS_ACK  = 2'b10
   } wdnmi_bus_e;

   // Stack pointer pairing states
   typedef enum logic [2:0] {
      WDNMI_SP_UNSET = 3'b001,
      WDNMI_SP_HALF  = 3'b010,
      WDNMI_SP_READY = 3'b100
   } wdnmi_sp_e;

endpackage

// ---- rtl/wdnmi_tick_if.sv ----
// Purpose: Carries the 256 Hz tick from the prescaler to the watchdog.
// Assumes: Both ends on core_clk.
// Notes:   tick is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface wdnmi_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface
`default_nettype wire

// ---- rtl/wdnmi_prescaler.sv ----
// Purpose: Divides the low-speed crystal clock down to a 256 Hz tick.
// Assumes: Crystal clock far slower than core_clk, sampled as a pin.
// Notes:   Free running from reset; shared by all users of the tick.
`timescale 1ns/1ps
`default_nettype none
module wdnmi_prescaler
(
   input  wire logic            core_clk,
   input  wire logic            rst,
   input  wire logic            low_speed_crystal_clock,
   wdnmi_tick_if.src            tick_bus
);

   logic                        sync1_reg;
   logic                        sync2_reg;
   logic                        sync3_reg;
   logic [wdnmi_pkg::DIV_W-1:0] div_reg;
   logic [wdnmi_pkg::DIV_W-1:0] div_next;
   logic                        tick_reg;
   wire                         osc_rise;
   wire                         div_wrap;

   // Two-stage synchroniser, third stage only for edge detection
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= low_speed_crystal_clock;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // One rising crystal edge advances the divide-by-128 stage
   assign osc_rise = sync2_reg & ~sync3_reg;
   assign div_wrap = osc_rise && (div_reg == wdnmi_pkg::DIV_LAST);
   assign div_next = osc_rise ? div_reg + wdnmi_pkg::DIV_ONE : div_reg;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         div_reg  <= wdnmi_pkg::DIV_RST;
         tick_reg <= 1'b0;
      end
      else
      begin
         div_reg  <= div_next;
         tick_reg <= div_wrap;
      end
   end

   assign tick_bus.tick = tick_reg;

   // Tick only ever follows the last divider stage
   tick_div_a:
      assert property (@(posedge core_clk) disable iff (rst)
         tick_reg |-> $past(div_reg) == wdnmi_pkg::DIV_LAST)
      else $error("tick without full divide by 128");

endmodule
`default_nettype wire

// ---- rtl/wdnmi_top.sv ----
// Purpose: Watchdog timer raising a non-maskable interrupt to the CPU core.
// Assumes: Avalon-MM slave with waitrequest, byte addressing, 32-bit data.
// Notes:   Every access takes two cycles; the NMI waits for stack pairing.
`timescale 1ns/1ps
`default_nettype none
module wdnmi_top
(
   input  wire logic                         core_clk,
   input  wire logic                         rst,
   input  wire logic [wdnmi_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                         avs_read,
   input  wire logic                         avs_write,
   input  wire logic [wdnmi_pkg::DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]                   avs_byteenable,
   output var  logic [wdnmi_pkg::DATA_W-1:0] avs_readdata,
   output logic                              avs_waitrequest,
   input  wire logic                         low_speed_crystal_clock,
   input  wire logic                         stack_pointer_first_half_wr,
   input  wire logic                         stack_pointer_second_half_wr,
   input  wire logic                         cpu_halted,
   input  wire logic                         nmi_ack,
   output logic                              nmi_request,
   output var  logic [15:0]                  nmi_vector,
   output logic                              halt_wake,
   output logic                              irq
);

   wdnmi_pkg::wdnmi_bus_e                bus_reg;
   wdnmi_pkg::wdnmi_bus_e                bus_next;
   wdnmi_pkg::wdnmi_sp_e                 sp_reg;
   wdnmi_pkg::wdnmi_sp_e                 sp_next;
   logic [wdnmi_pkg::CNT_W-1:0]          count_reg;
   logic [wdnmi_pkg::CNT_W-1:0]          count_next;
   logic                                 run_enable_reg;
   logic                                 run_enable_next;
   logic                                 nmi_pending_reg;
   logic                                 nmi_pending_next;
   logic [wdnmi_pkg::IRQ_W-1:0]          status_reg;
   logic [wdnmi_pkg::IRQ_W-1:0]          status_next;
   logic [wdnmi_pkg::IRQ_W-1:0]          irq_en_reg;
   logic [wdnmi_pkg::IRQ_W-1:0]          irq_en_next;
   logic [wdnmi_pkg::DATA_W-1:0]         readdata_reg;
   logic [wdnmi_pkg::DATA_W-1:0]         read_mux;
   logic [15:0]                          vector_reg;
   wire                                  tick;
   wire                                  bus_req;
   wire                                  bus_done;
   wire                                  wr_fire;
   wire                                  ctrl_hit;
   wire                                  stat_hit;
   wire                                  clr_hit;
   wire                                  en_hit;
   wire                                  count_hit;
   wire                                  ctrl_wr;
   wire                                  clear_fire;
   wire                                  overflow;
   wire                                  nmi_taken;
   wire                                  sp_ready;
   wire  [wdnmi_pkg::IRQ_W-1:0]          irq_event;
   wire  [wdnmi_pkg::IRQ_W-1:0]          irq_clr_mask;

   // Tick source shared through the carrier interface
   wdnmi_tick_if tick_link ();

   wdnmi_prescaler u_prescaler
   (
      .core_clk                (core_clk),
      .rst                     (rst),
      .low_speed_crystal_clock (low_speed_crystal_clock),
      .tick_bus                (tick_link.src)
   );

   assign tick = tick_link.tick;

   // Address decode: byte address is register index times four
   assign ctrl_hit  = avs_address == {wdnmi_pkg::CTRL_IDX, 2'b00};
   assign stat_hit  = avs_address == {wdnmi_pkg::STAT_IDX, 2'b00};
   assign clr_hit   = avs_address == {wdnmi_pkg::IRQ_CLR_IDX, 2'b00};
   assign en_hit    = avs_address == {wdnmi_pkg::IRQ_EN_IDX, 2'b00};
   assign count_hit = avs_address == {wdnmi_pkg::COUNT_IDX, 2'b00};

   // Fixed one wait state keeps readdata a clean flip-flop output
   assign bus_req         = avs_read | avs_write;
   assign bus_done        = bus_req && (bus_reg == wdnmi_pkg::WDNMI_BUS_ACK);
   assign avs_waitrequest = bus_req && (bus_reg != wdnmi_pkg::WDNMI_BUS_ACK);
   assign wr_fire         = bus_done && avs_write && avs_byteenable[0];

   always_comb
   begin
      case (bus_reg)
         wdnmi_pkg::WDNMI_BUS_IDLE:
            bus_next = bus_req ? wdnmi_pkg::WDNMI_BUS_ACK
                               : wdnmi_pkg::WDNMI_BUS_IDLE;
         wdnmi_pkg::WDNMI_BUS_ACK:
            bus_next = wdnmi_pkg::WDNMI_BUS_IDLE;
         default:
            bus_next = wdnmi_pkg::WDNMI_BUS_IDLE;
      endcase
   end

   // Read selection; write-only and unmapped words read as zero
   always_comb
   begin
      read_mux = '0;
      if (ctrl_hit)
         read_mux[wdnmi_pkg::CTRL_EN_BIT] = run_enable_reg;
      else if (stat_hit)
         read_mux[wdnmi_pkg::IRQ_W-1:0] = status_reg;
      else if (en_hit)
         read_mux[wdnmi_pkg::IRQ_W-1:0] = irq_en_reg;
      else if (count_hit)
         read_mux[wdnmi_pkg::CNT_W-1:0] = count_reg;
   end

   // Control writes: enable stores, clear is a strobe only
   assign ctrl_wr    = wr_fire && ctrl_hit;
   assign clear_fire = ctrl_wr
                       && avs_writedata[wdnmi_pkg::CTRL_CLR_BIT];
   assign run_enable_next = ctrl_wr
                            ? avs_writedata[wdnmi_pkg::CTRL_EN_BIT]
                            : run_enable_reg;

   // Counter holds while disabled, so a restart resumes the old count
   always_comb
   begin
      if (!run_enable_reg)
         count_next = count_reg;
      else if (clear_fire)
         count_next = wdnmi_pkg::CNT_RST;
      else if (tick)
         count_next = count_reg + wdnmi_pkg::CNT_ONE;
      else
         count_next = count_reg;
   end

   // Overflow of the final stage; halt does not gate it
   assign overflow = run_enable_reg && tick && !clear_fire
                     && (count_reg == wdnmi_pkg::CNT_MAX);

   // Pending NMI: overflow wins over a same-cycle acknowledge
   assign nmi_taken = nmi_request && nmi_ack;
   always_comb
   begin
      if (!run_enable_reg)
         nmi_pending_next = 1'b0;
      else if (overflow)
         nmi_pending_next = 1'b1;
      else if (nmi_taken)
         nmi_pending_next = 1'b0;
      else
         nmi_pending_next = nmi_pending_reg;
   end

   // Stack pointer pairing; a first-half write disarms until the second
   always_comb
   begin
      case (sp_reg)
         wdnmi_pkg::WDNMI_SP_UNSET,
         wdnmi_pkg::WDNMI_SP_READY:
            if (stack_pointer_first_half_wr && stack_pointer_second_half_wr)
               sp_next = wdnmi_pkg::WDNMI_SP_READY;
            else if (stack_pointer_first_half_wr)
               sp_next = wdnmi_pkg::WDNMI_SP_HALF;
            else
               sp_next = sp_reg;
         wdnmi_pkg::WDNMI_SP_HALF:
            sp_next = stack_pointer_second_half_wr
                      ? wdnmi_pkg::WDNMI_SP_READY
                      : wdnmi_pkg::WDNMI_SP_HALF;
         default:
            sp_next = wdnmi_pkg::WDNMI_SP_UNSET;
      endcase
   end

   // No interrupt-enable flag enters this path: the request is not maskable
   assign sp_ready    = sp_reg == wdnmi_pkg::WDNMI_SP_READY;
   assign nmi_request = nmi_pending_reg && sp_ready;
   assign halt_wake   = nmi_request && cpu_halted;
   assign nmi_vector  = vector_reg;

   // Interrupt status: events are sticky, a set beats a clear
   assign irq_event[wdnmi_pkg::IRQ_TIMEOUT_BIT] = overflow;
   assign irq_event[wdnmi_pkg::IRQ_ACCEPT_BIT]  = nmi_taken;
   assign irq_clr_mask = (wr_fire && clr_hit)
                         ? avs_writedata[wdnmi_pkg::IRQ_W-1:0] : '0;
   assign irq_en_next  = (wr_fire && en_hit)
                         ? avs_writedata[wdnmi_pkg::IRQ_W-1:0] : irq_en_reg;

   genvar g;
   generate
      for (g = 0; g < wdnmi_pkg::IRQ_W; g++)
      begin : g_status
         assign status_next[g] = irq_event[g]
                                 | (status_reg[g] & ~irq_clr_mask[g]);
      end
   endgenerate

   assign irq = |(status_reg & irq_en_reg);

   // Bus and pairing state
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         bus_reg      <= wdnmi_pkg::WDNMI_BUS_IDLE;
         sp_reg       <= wdnmi_pkg::WDNMI_SP_UNSET;
         readdata_reg <= '0;
      end
      else
      begin
         bus_reg      <= bus_next;
         sp_reg       <= sp_next;
         readdata_reg <= read_mux;
      end
   end

   assign avs_readdata = readdata_reg;

   // Watchdog core state; reset starts a full period with counting on
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         count_reg       <= wdnmi_pkg::CNT_RST;
         run_enable_reg  <= wdnmi_pkg::CTRL_EN_RST;
         nmi_pending_reg <= 1'b0;
         vector_reg      <= wdnmi_pkg::NMI_VECTOR;
      end
      else
      begin
         count_reg       <= count_next;
         run_enable_reg  <= run_enable_next;
         nmi_pending_reg <= nmi_pending_next;
         vector_reg      <= wdnmi_pkg::NMI_VECTOR;
      end
   end

   // Interrupt status and enable
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         status_reg <= wdnmi_pkg::IRQ_RST;
         irq_en_reg <= wdnmi_pkg::IRQ_RST;
      end
      else
      begin
         status_reg <= status_next;
         irq_en_reg <= irq_en_next;
      end
   end

   // The counter moves only on a tick or a clear
   tick_gate_a:
      assert property (@(posedge core_clk) disable iff (rst)
         (!tick && !clear_fire) |=> $stable(count_reg))
      else $error("counter moved without tick or clear");

   // Running with a zero count straight after reset release
   start_run_a:
      assert property (@(posedge core_clk)
         $fell(rst) |-> run_enable_reg && (count_reg == 10'h000))
      else $error("watchdog not running from zero after reset");

   // Reset sets enable and clears the count
   reset_val_a:
      assert property (@(posedge core_clk)
         rst |=> run_enable_reg && (count_reg == 10'h000)
                 && !nmi_pending_reg)
      else $error("reset values wrong");

   // Final-stage overflow wraps to zero and raises the NMI
   overflow_nmi_a:
      assert property (@(posedge core_clk) disable iff (rst)
         (run_enable_reg && tick && !clear_fire && count_reg == 10'h3FF)
         |=> nmi_pending_reg && (count_reg == 10'h000))
      else $error("overflow did not raise NMI");

   // The NMI rises only from a full count
   timeout_cause_a:
      assert property (@(posedge core_clk) disable iff (rst)
         $rose(nmi_pending_reg) |-> $past(count_reg) == 10'h3FF
                                    && $past(tick))
      else $error("NMI raised before full timeout");

   // Halt does not stop counting, and a halted CPU is woken
   halt_count_a:
      assert property (@(posedge core_clk) disable iff (rst)
         (cpu_halted && tick && run_enable_reg && !clear_fire)
         |=> count_reg == $past(count_reg) + 10'h001)
      else $error("counter stalled during halt");

   halt_wake_a:
      assert property (@(posedge core_clk) disable iff (rst)
         (nmi_pending_reg && sp_ready && cpu_halted) |-> halt_wake)
      else $error("halted CPU not woken by NMI");

   // A raised request stands until taken, disabled or re-armed by a first-half write; no interrupt-enable flag withdraws it
   nmi_unmasked_a:
      assert property (@(posedge core_clk) disable iff (rst)
         (nmi_request && run_enable_reg && !nmi_ack
          && !stack_pointer_first_half_wr)
         |=> nmi_request)
      else $error("NMI withdrawn before acceptance");

   // No request before the stack pointer pair is complete
   sp_hold_a:
      assert property (@(posedge core_clk) disable iff (rst)
         stack_pointer_first_half_wr && !stack_pointer_second_half_wr
         |=> !nmi_request)
      else $error("NMI issued during stack pointer reload");

   // Request carries the fixed vector
   vector_fix_a:
      assert property (@(posedge core_clk) disable iff (rst)
         nmi_request |-> nmi_vector == 16'h0100)
      else $error("wrong NMI vector");

   // Disabling stops counting and drops the NMI within two cycles
   disable_stop_a:
      assert property (@(posedge core_clk) disable iff (rst)
         (ctrl_wr && !avs_writedata[1])
         |=> !run_enable_reg ##1 !nmi_pending_reg && $stable(count_reg))
      else $error("disable did not stop watchdog");

   // A clear strobe zeroes the running counter
   clear_zero_a:
      assert property (@(posedge core_clk) disable iff (rst)
         (clear_fire && run_enable_reg) |=> count_reg == 10'h000)
      else $error("clear strobe did not zero counter");

   // Control read shows enable only
   ctrl_read_a:
      assert property (@(posedge core_clk) disable iff (rst)
         (bus_done && avs_read && ctrl_hit)
         |-> avs_readdata[0] == 1'b0 && avs_readdata[31:2] == 30'h0
             && avs_readdata[1] == run_enable_reg)
      else $error("control read shows write-only bits");

endmodule
`default_nettype wire

// ---- verification/wdnmi_cpu_model.sv ----
// Purpose: Behavioural CPU core that takes the watchdog NMI.
// Assumes: One core_clk domain; bench commands are one-cycle pulses.
// Notes:   Interrupt-enable flag is taken as 0 throughout.
`timescale 1ns/1ps
`default_nettype none
module wdnmi_cpu_model
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        nmi_request,
   input  wire logic [15:0] nmi_vector,
   input  wire logic        halt_wake,
   input  wire logic        sp_first_go,
   input  wire logic        sp_second_go,
   input  wire logic        halt_go,
   input  wire logic        ack_allow,
   output logic             stack_pointer_first_half_wr,
   output logic             stack_pointer_second_half_wr,
   output logic             cpu_halted,
   output logic             nmi_ack,
   output logic [15:0]      accepted_vector,
   output logic [7:0]       accept_total
);
   logic sp_half_reg;
   logic sp_paired_reg;

   // Stack pointer writes, halt and NMI acceptance
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         stack_pointer_first_half_wr  <= 1'b0;
         stack_pointer_second_half_wr <= 1'b0;
         cpu_halted      <= 1'b0;
         nmi_ack         <= 1'b0;
         accepted_vector <= 16'h0000;
         accept_total    <= 8'h00;
         sp_half_reg     <= 1'b0;
         sp_paired_reg   <= 1'b0;
      end
      else
      begin
         stack_pointer_first_half_wr  <= sp_first_go;
         stack_pointer_second_half_wr <= sp_second_go;
         nmi_ack <= 1'b0;
         // A pair only counts when the first half leads
         if (sp_first_go)
         begin
            sp_half_reg   <= 1'b1;
            sp_paired_reg <= 1'b0;
         end
         else if (sp_second_go && sp_half_reg)
         begin
            sp_half_reg   <= 1'b0;
            sp_paired_reg <= 1'b1;
         end
         if (halt_wake)
            cpu_halted <= 1'b0;
         else if (halt_go)
            cpu_halted <= 1'b1;
         // Enable flag is clear, yet the NMI is taken once paired
         if (nmi_request && sp_paired_reg && ack_allow && !nmi_ack)
         begin
            nmi_ack         <= 1'b1;
            accepted_vector <= nmi_vector;
            accept_total    <= accept_total + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verification/test_watchdog_nmi_timer.sv ----
// Purpose: Self-checking bench for the watchdog NMI timer.
// Assumes: Crystal pin toggled every core cycle, so one tick per 256.
// Notes:   The full timeout is run once; it is the long part of the run.
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_nmi_timer;
   localparam int TICK_CYC = 2 * wdnmi_pkg::LSC_DIV;
   localparam logic [17:0] A_CTRL = {wdnmi_pkg::CTRL_IDX, 2'b00};
   localparam logic [17:0] A_STAT = {wdnmi_pkg::STAT_IDX, 2'b00};
   localparam logic [17:0] A_CLR  = {wdnmi_pkg::IRQ_CLR_IDX, 2'b00};
   localparam logic [17:0] A_IEN  = {wdnmi_pkg::IRQ_EN_IDX, 2'b00};
   localparam logic [17:0] A_CNT  = {wdnmi_pkg::COUNT_IDX, 2'b00};
   localparam logic [17:0] A_NONE = 18'h3FC20;
   logic core_clk, rst, avs_read, avs_write, avs_waitrequest, lsc;
   logic [17:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, hold;
   logic [3:0]  avs_byteenable;
   logic sp1_wr, sp2_wr, cpu_halted, nmi_ack, nmi_request, halt_wake, irq;
   logic sp_first_go, sp_second_go, halt_go, ack_allow;
   logic [15:0] nmi_vector, accepted_vector;
   logic [7:0]  accept_total;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   int t0;

   wdnmi_top u_wdnmi_top (.core_clk(core_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .low_speed_crystal_clock(lsc),
      .stack_pointer_first_half_wr(sp1_wr),
      .stack_pointer_second_half_wr(sp2_wr), .cpu_halted(cpu_halted),
      .nmi_ack(nmi_ack), .nmi_request(nmi_request),
      .nmi_vector(nmi_vector), .halt_wake(halt_wake), .irq(irq));
   wdnmi_cpu_model u_wdnmi_cpu_model (.core_clk(core_clk), .rst(rst),
      .nmi_request(nmi_request), .nmi_vector(nmi_vector),
      .halt_wake(halt_wake), .sp_first_go(sp_first_go),
      .sp_second_go(sp_second_go), .halt_go(halt_go),
      .ack_allow(ack_allow), .stack_pointer_first_half_wr(sp1_wr),
      .stack_pointer_second_half_wr(sp2_wr), .cpu_halted(cpu_halted),
      .nmi_ack(nmi_ack), .accepted_vector(accepted_vector),
      .accept_total(accept_total));

   // 40 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Fast crystal stand-in keeps the four second timeout reachable
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      lsc <= ~lsc;
   end

   task automatic stop_test();
      $display("Checks %0d, errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check_eq(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s got %h", $time, what, got);
      end
   endtask

   task automatic check_in(input logic [31:0] got, input int lo,
                           input int hi, input string what);
      check_count++;
      if ($isunknown(got) || got < lo || got > hi)
      begin
         err_total++;
         $display("wrong value at %0t: %s got %0d", $time, what, got);
      end
   endtask

   // One Avalon transfer; held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [17:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= ~wr;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      check_in(n, 2, 2, "bus answer");
   endtask

   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp,
                         input string what);
      bus(1'b0, a, 32'h00000000, 4'hF);
      check_eq(rd, exp, what);
   endtask

   task automatic wait_ticks(input int n);
      repeat (n * TICK_CYC) @(posedge core_clk);
   endtask

   // Pulse one command of the CPU model: 0 first, 1 second, 2 halt
   task automatic go(input int which);
      @(posedge core_clk);
      if (which == 0)
         sp_first_go <= 1'b1;
      else if (which == 1)
         sp_second_go <= 1'b1;
      else
         halt_go <= 1'b1;
      @(posedge core_clk);
      sp_first_go  <= 1'b0;
      sp_second_go <= 1'b0;
      halt_go      <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask

   // Watchdog against a hung run
   initial
   begin
      #(TICK_CYC * 1300 * 25);
      err_total++;
      stop_test();
   end

   // Main sequence
   initial
   begin
      rst = 1'b1;
      lsc = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hF;
      {sp_first_go, sp_second_go, halt_go, ack_allow} = 4'h0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      check_eq(32'(nmi_vector), 32'h00000100, "vector");
      rd_chk(A_CTRL, 32'h00000002, "ctrl reset");
      rd_chk(A_STAT, 32'h00000000, "status reset");
      rd_chk(A_IEN, 32'h00000000, "enable reset");
      rd_chk(A_CNT, 32'h00000000, "count reset");
      rd_chk(A_NONE, 32'h00000000, "unmapped");
      wait_ticks(4);
      bus(1'b0, A_CNT, 32'h0, 4'hF);
      check_in(rd, 3, 4, "free count");
      wr(A_CTRL, 32'h00000003);
      bus(1'b0, A_CNT, 32'h0, 4'hF);
      check_in(rd, 0, 1, "cleared count");
      wait_ticks(3);
      wr(A_CTRL, 32'h00000002);
      bus(1'b0, A_CNT, 32'h0, 4'hF);
      check_in(rd, 2, 4, "zero strobe");
      wr(A_CTRL, 32'h00000000);
      rd_chk(A_CTRL, 32'h00000000, "ctrl off");
      bus(1'b0, A_CNT, 32'h0, 4'hF);
      hold = rd;
      wait_ticks(3);
      wr(A_CTRL, 32'h00000001);
      rd_chk(A_CNT, hold, "held count");
      bus(1'b1, A_CTRL, 32'h00000002, 4'hE);
      rd_chk(A_CTRL, 32'h00000000, "lane off");
      wr(A_CTRL, 32'h00000002);
      rd_chk(A_CTRL, 32'h00000002, "ctrl on");
      wr(A_STAT, 32'h00000003);
      wr(A_NONE, 32'hFFFFFFFF);
      rd_chk(A_STAT, 32'h00000000, "status ro");
      wr(A_IEN, 32'h00000001);
      rd_chk(A_IEN, 32'h00000001, "irq enable");
      // Full timeout while halted and before the stack pair is set
      go(2);
      wr(A_CTRL, 32'h00000003);
      t0 = cyc;
      while (irq !== 1'b1 && cyc - t0 < 1100 * TICK_CYC)
         @(posedge core_clk);
      check_in(cyc - t0, 1023 * TICK_CYC, 1024 * TICK_CYC + 8,
               "timeout span");
      check_eq(32'(nmi_request), 32'h0, "held off");
      check_eq(32'(cpu_halted), 32'h1, "still halted");
      rd_chk(A_STAT, 32'h00000001, "timeout flag");
      wr(A_IEN, 32'h00000000);
      @(posedge core_clk);
      check_eq(32'(irq), 32'h0, "masked");
      wr(A_IEN, 32'h00000001);
      @(posedge core_clk);
      check_eq(32'(irq), 32'h1, "unmasked");
      go(1);
      check_eq(32'(nmi_request), 32'h0, "second alone");
      go(0);
      check_eq(32'(nmi_request), 32'h0, "first only");
      go(1);
      check_eq(32'(nmi_request), 32'h1, "paired");
      check_eq(32'(cpu_halted), 32'h0, "woken");
      ack_allow <= 1'b1;
      repeat (4) @(posedge core_clk);
      check_eq(32'(nmi_request), 32'h0, "acked");
      check_eq(32'(accept_total), 32'h1, "accepts");
      check_eq(32'(accepted_vector), 32'h00000100, "taken");
      rd_chk(A_STAT, 32'h00000003, "accept flag");
      wr(A_CLR, 32'h00000003);
      rd_chk(A_STAT, 32'h00000000, "flags cleared");
      check_eq(32'(irq), 32'h0, "irq low");
      stop_test();
   end
endmodule
`default_nettype wire
